// File: pkg/debug_event_pkg.sv
// Constants for the debug event pin logic and its register port
package debug_event_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_MASK = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_UNIT = 4'hC;

  // ****************************************
  // Control register layout
  // ****************************************
  localparam int CTRL_W = 4;
  localparam int CTRL_IN_CTL_LSB = 0;
  localparam int CTRL_OUT_SEL_LSB = 2;
  localparam int FIELD_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  // Event input control codes
  localparam logic [FIELD_W-1:0] IN_CTL_BREAK = 2'b01;
  // Event output select codes
  localparam logic [FIELD_W-1:0] OUT_SEL_ENTRY = 2'b01;
  localparam logic [FIELD_W-1:0] OUT_SEL_STATUS = 2'b10;

  // ****************************************
  // Status and mask layout
  // ****************************************
  localparam int STAT_W = 3;
  localparam int STAT_EXT_BREAK_BIT = 0;
  localparam int STAT_ENTRY_BIT = 1;
  localparam int STAT_HIT_BIT = 2;
  localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 3'h0;

  // ****************************************
  // Breakpoint and watchpoint units
  // ****************************************
  localparam int NUM_UNITS = 4;
  localparam logic [NUM_UNITS-1:0] UNIT_RST = 4'h0;

  // ****************************************
  // Bus responses and reset levels
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic PIN_IDLE = 1'b1;

endpackage

// File: rtl/sticky_flags.sv
// Sticky event flags, cleared as a group, where a new event beats the clear
`timescale 1ns/1ps
module sticky_flags #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Events and clear
  input wire logic [W-1:0] set,
  input wire logic clr,
  // Flag state
  output logic [W-1:0] q
);

  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb
  begin
    q_next = (q_reg & ~{W{clr}}) | set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_reg <= '0;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule

// File: rtl/axil_slave_port.sv
// AXI4-Lite slave handshake: one write and one read in flight at a time
`timescale 1ns/1ps
module axil_slave_port (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [debug_event_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [debug_event_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [debug_event_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data
  input wire logic [debug_event_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [debug_event_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register file side
  output logic wr_en,
  output logic [debug_event_pkg::ADDR_W-1:0] wr_addr,
  output logic [debug_event_pkg::DATA_W-1:0] wr_data,
  output logic [debug_event_pkg::STRB_W-1:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_en,
  output logic [debug_event_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [debug_event_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_ok
);
  import debug_event_pkg::*;

  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic [STRB_W-1:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  // Address and data are parked until both are present
  assign wr_en = aw_got_reg && w_got_reg && !bvalid_reg;
  assign wr_addr = awaddr_reg;
  assign wr_data = wdata_reg;
  assign wr_strb = wstrb_reg;
  assign rd_en = s_axi_arvalid && arready_reg;
  assign rd_addr = s_axi_araddr;

  always_comb
  begin
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && awready_reg)
    begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg)
    begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_en)
    begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_got_next && !bvalid_next;
    wready_next = !w_got_next && !bvalid_next;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rd_en)
    begin
      rvalid_next = 1'b1;
      rdata_next = rd_data;
      rresp_next = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= DATA_RST;
      wstrb_reg <= '0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= DATA_RST;
      rresp_reg <= RESP_OKAY;
    end
    else
    begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule

// File: rtl/debug_event_pin_logic.sv
// Debug event input and output pin logic with its AXI4-Lite register file
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

// Summary of operation
// R1: Event input control 01: each falling edge on event input raises a breakpoint.
// R2: External equipment holds event input low one CPU clock after falling.
// R3: An event input breakpoint sets the external break flag in debug status.
// R4: Output select 01: event output low exactly one clock per debug entry.
// R5: Units with output-on-condition set show their hit status on event output.
// R6: Unit hit status reaches event output only while output select is 10.
// R7: Other input control values ignore the input; idle event output stays high.
module debug_event_pin_logic (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [debug_event_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [debug_event_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [debug_event_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [debug_event_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [debug_event_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU debug state
  input wire logic debug_mode,
  input wire logic [debug_event_pkg::NUM_UNITS-1:0] unit_hit,
  output logic break_request,
  // Event pins
  input wire logic event_input_pin,
  output logic event_output_pin,
  // Interrupt
  output logic irq
);
  import debug_event_pkg::*;

  // ****************************************
  // Register port
  // ****************************************
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;

  axil_slave_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ****************************************
  // Registers
  // ****************************************
  logic [CTRL_W-1:0] debug_control_reg, debug_control_next;
  logic [STAT_W-1:0] mask_reg, mask_next;
  logic [NUM_UNITS-1:0] unit_cond_reg, unit_cond_next;
  logic [STAT_W-1:0] debug_status_reg;
  logic [STAT_W-1:0] status_set;
  logic status_clr;
  logic [FIELD_W-1:0] event_in_control_field;
  logic [FIELD_W-1:0] event_out_select_field;

  assign event_in_control_field = debug_control_reg[CTRL_IN_CTL_LSB +: FIELD_W];
  assign event_out_select_field = debug_control_reg[CTRL_OUT_SEL_LSB +: FIELD_W];

  // Decode for reads; the status clears on the read that returns it
  always_comb
  begin
    rd_data = DATA_RST;
    rd_ok = 1'b1;
    case (rd_addr)
      OFF_CTRL: rd_data[CTRL_W-1:0] = debug_control_reg;
      OFF_STATUS: rd_data[STAT_W-1:0] = debug_status_reg;
      OFF_MASK: rd_data[STAT_W-1:0] = mask_reg;
      OFF_UNIT: rd_data[NUM_UNITS-1:0] = unit_cond_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  // All fields live in byte lane 0, so only that strobe matters
  always_comb
  begin
    debug_control_next = debug_control_reg;
    mask_next = mask_reg;
    unit_cond_next = unit_cond_reg;
    wr_ok = 1'b1;
    case (wr_addr)
      OFF_CTRL:
      begin
        if (wr_en && wr_strb[0])
        begin
          debug_control_next = wr_data[CTRL_W-1:0];
        end
      end
      OFF_STATUS: wr_ok = 1'b1;
      OFF_MASK:
      begin
        if (wr_en && wr_strb[0])
        begin
          mask_next = wr_data[STAT_W-1:0];
        end
      end
      OFF_UNIT:
      begin
        if (wr_en && wr_strb[0])
        begin
          unit_cond_next = wr_data[NUM_UNITS-1:0];
        end
      end
      default: wr_ok = 1'b0;
    endcase
  end

  // ****************************************
  // Event logic
  // ****************************************
  logic pin_prev_reg;
  logic mode_prev_reg;
  logic break_request_reg, break_request_next;
  logic event_output_pin_reg, event_output_pin_next;
  logic irq_reg, irq_next;
  logic pin_fall;
  logic entry_rise;
  logic unit_active;

  always_comb
  begin
    pin_fall = pin_prev_reg && !event_input_pin;
    entry_rise = debug_mode && !mode_prev_reg;
    unit_active = |(unit_hit & unit_cond_reg); // R5
    // Any other control value leaves the input without effect
    break_request_next = pin_fall && (event_in_control_field == IN_CTL_BREAK); // R1 R7
    case (event_out_select_field)
      OUT_SEL_ENTRY: event_output_pin_next = !entry_rise; // R4
      OUT_SEL_STATUS: event_output_pin_next = !unit_active; // R5 R6
      default: event_output_pin_next = PIN_IDLE; // R6 R7
    endcase
    status_set = '0;
    status_set[STAT_EXT_BREAK_BIT] = break_request_next; // R3
    status_set[STAT_ENTRY_BIT] = entry_rise;
    status_set[STAT_HIT_BIT] = unit_active;
    status_clr = rd_en && (rd_addr == OFF_STATUS);
    irq_next = |(debug_status_reg & mask_reg);
  end

  sticky_flags #(
    .W(STAT_W)
  ) u_status (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(status_set),
    .clr(status_clr),
    .q(debug_status_reg)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      debug_control_reg <= CTRL_RST;
      mask_reg <= MASK_RST;
      unit_cond_reg <= UNIT_RST;
      pin_prev_reg <= PIN_IDLE;
      mode_prev_reg <= 1'b0;
      break_request_reg <= 1'b0;
      event_output_pin_reg <= PIN_IDLE;
      irq_reg <= 1'b0;
    end
    else
    begin
      debug_control_reg <= debug_control_next;
      mask_reg <= mask_next;
      unit_cond_reg <= unit_cond_next;
      pin_prev_reg <= event_input_pin;
      mode_prev_reg <= debug_mode;
      break_request_reg <= break_request_next;
      event_output_pin_reg <= event_output_pin_next;
      irq_reg <= irq_next;
    end
  end

  assign break_request = break_request_reg;
  assign event_output_pin = event_output_pin_reg;
  assign irq = irq_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_break_on_fall;
    (event_in_control_field == IN_CTL_BREAK) && $fell(event_input_pin) |=> break_request;
  endproperty
  a_break_on_fall: assert property (p_break_on_fall) // R1
    else $error("falling event input did not raise a breakpoint");

  property p_break_sets_flag;
    break_request |-> debug_status_reg[STAT_EXT_BREAK_BIT];
  endproperty
  a_break_sets_flag: assert property (p_break_sets_flag) // R3
    else $error("breakpoint left the external break flag clear");

  property p_entry_pulse_low;
    (event_out_select_field == OUT_SEL_ENTRY) && $rose(debug_mode) |=> !event_output_pin;
  endproperty
  a_entry_pulse_low: assert property (p_entry_pulse_low) // R4
    else $error("debug entry did not pull the event output low");

  property p_entry_pulse_one;
    (event_out_select_field == OUT_SEL_ENTRY) && !$rose(debug_mode) |=> event_output_pin;
  endproperty
  a_entry_pulse_one: assert property (p_entry_pulse_one) // R4
    else $error("event output low without a debug entry");

  property p_hit_shown;
    (event_out_select_field == OUT_SEL_STATUS) && |(unit_hit & unit_cond_reg)
      |=> !event_output_pin;
  endproperty
  a_hit_shown: assert property (p_hit_shown) // R5
    else $error("enabled unit hit not shown on event output");

  property p_hit_gated;
    (event_out_select_field != OUT_SEL_STATUS) && (event_out_select_field != OUT_SEL_ENTRY)
      |=> event_output_pin;
  endproperty
  a_hit_gated: assert property (p_hit_gated) // R6
    else $error("event output driven while its function is off");

  property p_input_ignored;
    (event_in_control_field != IN_CTL_BREAK) |=> !break_request;
  endproperty
  a_input_ignored: assert property (p_input_ignored) // R7
    else $error("breakpoint raised with event input disabled");

  c_break: cover property (break_request ##[1:20] irq);
  c_entry: cover property ((event_out_select_field == OUT_SEL_ENTRY) ##1 !event_output_pin);
  c_hit: cover property ((event_out_select_field == OUT_SEL_STATUS) ##1 !event_output_pin [*2]);
  c_clear: cover property (status_clr && |status_set);

endmodule

// File: bench/event_partner.sv
// External trigger source and scope model on the event pins
`timescale 1ns/1ps
module event_partner (
  // Clock
  input wire logic aclk,
  // Event pins
  output logic event_input_pin,
  input wire logic event_output_pin
);
  int scope_lows;

  initial
  begin
    event_input_pin = 1'b1;
    scope_lows = 0;
  end

  // ****************************************
  // Scope: counts cycles the output is low
  // ****************************************
  always @(posedge aclk)
  begin
    if (event_output_pin === 1'b0)
      scope_lows <= scope_lows + 1;
  end

  // ****************************************
  // Trigger: falling edge, held low n cycles
  // ****************************************
  task automatic fall(input int n);
    @(posedge aclk);
    event_input_pin <= 1'b0;
    repeat (n) @(posedge aclk);
    event_input_pin <= 1'b1;
    @(posedge aclk);
  endtask
endmodule

// File: bench/debug_event_pin_logic_bench.sv
// Self-checking bench for the debug event pin logic
`timescale 1ns/1ps
module debug_event_pin_logic_bench;
  import debug_event_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, debug_mode;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata;
  logic [STRB_W-1:0] wstrb;
  logic [NUM_UNITS-1:0] unit_hit;
  logic awready, wready, bvalid, arready, rvalid, break_request, evi, evo, irq;
  logic [1:0] bresp, rresp;
  logic [DATA_W-1:0] rdata;
  int error_cnt, samples_checked, cyc, brk_cnt;

  debug_event_pin_logic i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .debug_mode(debug_mode), .unit_hit(unit_hit), .break_request(break_request),
    .event_input_pin(evi), .event_output_pin(evo), .irq(irq)
  );
  event_partner i_partner (.aclk(aclk), .event_input_pin(evi), .event_output_pin(evo));

  // ****************************************
  // Clock, watchdog and pulse counting
  // ****************************************
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (break_request === 1'b1)
      brk_cnt <= brk_cnt + 1;
    // Generous ceiling: the whole run needs well under a thousand cycles
    if (cyc == 5000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  // ****************************************
  // Compare, bus and closing tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    bit a_ok, w_ok;
    a_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) a_ok = 1;
      if (wready === 1'b1) w_ok = 1;
      if (a_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (!(a_ok && w_ok));
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic axr(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    chk("rdata", exp, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_regs();
    chk("idle output", 1, {31'h0, evo});
    axr(OFF_CTRL, 0, RESP_OKAY);
    axr(OFF_STATUS, 0, RESP_OKAY);
    axr(OFF_MASK, 0, RESP_OKAY);
    axr(OFF_UNIT, 0, RESP_OKAY);
    axw(OFF_CTRL, 32'hFFFF_FFFF, RESP_OKAY);
    axr(OFF_CTRL, 32'h0000_000F, RESP_OKAY);
    axw(OFF_STATUS, 32'h0000_0007, RESP_OKAY);
    axr(OFF_STATUS, 0, RESP_OKAY);
    axw(4'h2, 32'h0000_0001, RESP_SLVERR);
    axr(4'h2, 0, RESP_SLVERR);
    // A write with byte lane 0 disabled must leave the control fields alone
    wstrb <= 4'hE;
    axw(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    wstrb <= 4'hF;
    axr(OFF_CTRL, 32'h0000_000F, RESP_OKAY);
  endtask

  task automatic t_break_in();
    int b0;
    axw(OFF_MASK, 32'h0000_0001, RESP_OKAY);
    axw(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
    b0 = brk_cnt;
    i_partner.fall(1);
    i_partner.fall(2);
    repeat (4) @(posedge aclk);
    chk("break pulses", 2, brk_cnt - b0);
    chk("irq raised", 1, {31'h0, irq});
    axr(OFF_STATUS, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 0, {31'h0, irq});
  endtask

  task automatic t_break_ignored();
    int b0;
    logic [1:0] codes [3] = '{2'b00, 2'b10, 2'b11};
    foreach (codes[i])
    begin
      axw(OFF_CTRL, {30'h0, codes[i]}, RESP_OKAY);
      b0 = brk_cnt;
      i_partner.fall(2);
      repeat (4) @(posedge aclk);
      chk("ignored break", 0, brk_cnt - b0);
      axr(OFF_STATUS, 0, RESP_OKAY);
    end
  endtask

  task automatic t_entry_pulse();
    int l0;
    axw(OFF_CTRL, 32'h0000_0004, RESP_OKAY);
    l0 = i_partner.scope_lows;
    @(posedge aclk);
    debug_mode <= 1'b1;
    repeat (5) @(posedge aclk);
    debug_mode <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("entry low cycles", 1, i_partner.scope_lows - l0);
    chk("masked irq", 0, {31'h0, irq});
    axr(OFF_STATUS, 32'h0000_0002, RESP_OKAY);
  endtask

  task automatic t_hit_out();
    int l0;
    logic [1:0] codes [3] = '{2'b00, 2'b01, 2'b11};
    axw(OFF_UNIT, 32'h0000_0002, RESP_OKAY);
    axw(OFF_CTRL, 32'h0000_0008, RESP_OKAY);
    l0 = i_partner.scope_lows;
    @(posedge aclk);
    unit_hit <= 4'b0010;
    repeat (3) @(posedge aclk);
    unit_hit <= 4'b0001;
    repeat (4) @(posedge aclk);
    unit_hit <= 4'b0000;
    repeat (2) @(posedge aclk);
    chk("hit low cycles", 3, i_partner.scope_lows - l0);
    axr(OFF_STATUS, 32'h0000_0004, RESP_OKAY);
    foreach (codes[i])
    begin
      axw(OFF_CTRL, {28'h0, codes[i], 2'b00}, RESP_OKAY);
      l0 = i_partner.scope_lows;
      @(posedge aclk);
      unit_hit <= 4'b0010;
      repeat (3) @(posedge aclk);
      unit_hit <= 4'b0000;
      repeat (2) @(posedge aclk);
      chk("hit gated", 0, i_partner.scope_lows - l0);
    end
  endtask

  initial
  begin
    error_cnt = 0; samples_checked = 0; cyc = 0; brk_cnt = 0;
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = '0; araddr = '0; wdata = '0;
    debug_mode = 1'b0; unit_hit = '0;
    wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_regs();
    t_break_in();
    t_break_ignored();
    t_entry_pulse();
    t_hit_out();
    wrap_up();
  end
endmodule
